// *** hdl/tmr_wave.sv ***
// 16-bit timer with waveform modes, compare outputs and APB register access
`timescale 1ns/1ps
module tmr_wave
  import tmr_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        ext_count_pin,
  output logic             compare_out_a,
  output logic             compare_out_a_oe,
  output logic             compare_out_b,
  output logic             compare_out_b_oe,
  output logic             irq
);

  // ***************************************************************
  // Functions
  // ***************************************************************
  function automatic tmr_mode_t decode_mode(input logic [3:0] m);
    tmr_mode_t d;
    d = '{fam: TMR_FAM_NORMAL, top_src: TMR_TOP_FIXED, fixed_top: TMR_MAX};
    case (m)
      4'h0: d = '{TMR_FAM_NORMAL, TMR_TOP_FIXED, TMR_MAX};
      4'h1: d = '{TMR_FAM_PC, TMR_TOP_FIXED, TMR_TOP_8};
      4'h2: d = '{TMR_FAM_PC, TMR_TOP_FIXED, TMR_TOP_9};
      4'h3: d = '{TMR_FAM_PC, TMR_TOP_FIXED, TMR_TOP_10};
      4'h4: d = '{TMR_FAM_CTC, TMR_TOP_CMPA, TMR_MAX};
      4'h5: d = '{TMR_FAM_FAST, TMR_TOP_FIXED, TMR_TOP_8};
      4'h6: d = '{TMR_FAM_FAST, TMR_TOP_FIXED, TMR_TOP_9};
      4'h7: d = '{TMR_FAM_FAST, TMR_TOP_FIXED, TMR_TOP_10};
      4'h8: d = '{TMR_FAM_PFC, TMR_TOP_CAPT, TMR_MAX};
      4'h9: d = '{TMR_FAM_PFC, TMR_TOP_CMPA, TMR_MAX};
      4'ha: d = '{TMR_FAM_PC, TMR_TOP_CAPT, TMR_MAX};
      4'hb: d = '{TMR_FAM_PC, TMR_TOP_CMPA, TMR_MAX};
      4'hc: d = '{TMR_FAM_CTC, TMR_TOP_CAPT, TMR_MAX};
      4'hd: d = '{TMR_FAM_RSVD, TMR_TOP_FIXED, TMR_MAX};
      4'he: d = '{TMR_FAM_FAST, TMR_TOP_CAPT, TMR_MAX};
      4'hf: d = '{TMR_FAM_FAST, TMR_TOP_CMPA, TMR_MAX};
      default: d = '{TMR_FAM_NORMAL, TMR_TOP_FIXED, TMR_MAX};
    endcase
    return d;
  endfunction

  // Next output level for one channel on a compare match
  function automatic logic match_level(input logic [1:0] om, input logic cur,
                                       input logic up, input logic pwm_dual,
                                       input logic tog_ok);
    logic r;
    r = cur;
    if (pwm_dual)
    begin
      if (om[1])
        r = om[0] ^ ~up;
      else if (om[0] && tog_ok)
        r = ~cur;
    end
    else if (om == 2'b01)
      r = tog_ok ? ~cur : cur;
    else if (om[1])
      r = om[0];
    return r;
  endfunction

  // ***************************************************************
  // Registers
  // ***************************************************************
  logic [7:0]  ctrl_a_reg;
  logic [4:0]  ctrl_b_reg;
  logic [15:0] count_value_reg;
  logic [15:0] compare_value_a_reg;
  logic [15:0] compare_value_b_reg;
  logic [15:0] cmp_buf_a_reg;
  logic [15:0] cmp_buf_b_reg;
  logic [15:0] capture_value_reg;
  logic [2:0]  status_reg;
  logic [2:0]  mask_reg;
  logic [1:0]  dir_reg;
  logic        count_up_reg;
  logic        block_match_reg;
  logic        pend_a_reg;
  logic        pend_b_reg;
  logic [TMR_PRE_W-1:0] pre_reg;
  logic        ext_prev_reg;
  logic        level_a_reg;
  logic        level_b_reg;

  logic [1:0]  chan_a_output_mode;
  logic [1:0]  chan_b_output_mode;
  logic [3:0]  waveform_mode_sel;
  logic [2:0]  tick_source_sel;
  tmr_mode_t   mode;
  logic [15:0] top_val;
  logic        timer_tick;
  logic        wr_en;
  logic        rd_en;
  logic        count_wr;
  logic        force_a;
  logic        force_b;
  logic        at_top;
  logic        at_bottom;
  logic        dual;
  logic        fast;
  logic        upd_now;
  logic        ovf_evt;
  logic        tog_ok;

  assign chan_a_output_mode = ctrl_a_reg[7:6];
  assign chan_b_output_mode = ctrl_a_reg[5:4];
  assign waveform_mode_sel  = {ctrl_b_reg[4:3], ctrl_a_reg[1:0]};
  assign tick_source_sel    = ctrl_b_reg[2:0];
  assign mode               = decode_mode(waveform_mode_sel);
  assign dual               = (mode.fam == TMR_FAM_PC) || (mode.fam == TMR_FAM_PFC);
  assign fast               = (mode.fam == TMR_FAM_FAST);

  // ***************************************************************
  // APB access
  // ***************************************************************
  assign wr_en    = psel && penable && pwrite && pready;
  assign rd_en    = psel && !penable && !pwrite;
  assign count_wr = wr_en && (paddr == TMR_COUNT_OFS);
  assign force_a  = wr_en && (paddr == TMR_FORCE_OFS) && pwdata[7];
  assign force_b  = wr_en && (paddr == TMR_FORCE_OFS) && pwdata[6];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pready <= 1'b0;
    else
      pready <= psel && !penable;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (rd_en || (psel && !penable))
    begin
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      case (paddr)
        TMR_CTRL_A_OFS: prdata <= {24'h000000, ctrl_a_reg};
        TMR_CTRL_B_OFS: prdata <= {27'h0000000, ctrl_b_reg};
        TMR_FORCE_OFS:  prdata <= 32'h0000_0000;
        TMR_COUNT_OFS:  prdata <= {16'h0000, count_value_reg};
        TMR_CMP_A_OFS:  prdata <= {16'h0000, cmp_buf_a_reg};
        TMR_CMP_B_OFS:  prdata <= {16'h0000, cmp_buf_b_reg};
        TMR_CAPT_OFS:   prdata <= {16'h0000, capture_value_reg};
        TMR_STATUS_OFS: prdata <= {29'h00000000, status_reg};
        TMR_MASK_OFS:   prdata <= {29'h00000000, mask_reg};
        TMR_DIR_OFS:    prdata <= {30'h00000000, dir_reg};
        default:        pslverr <= 1'b1;
      endcase
    end
  end

  // Control registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_a_reg        <= TMR_CTRL_A_RST;
      ctrl_b_reg        <= TMR_CTRL_B_RST;
      cmp_buf_a_reg     <= TMR_BOTTOM;
      cmp_buf_b_reg     <= TMR_BOTTOM;
      capture_value_reg <= TMR_BOTTOM;
      mask_reg          <= 3'h0;
      dir_reg           <= 2'h0;
    end
    else if (wr_en)
    begin
      case (paddr)
        TMR_CTRL_A_OFS: ctrl_a_reg <= pwdata[7:0] & TMR_CTRL_A_WMSK;
        TMR_CTRL_B_OFS: ctrl_b_reg <= pwdata[4:0];
        TMR_CMP_A_OFS:  cmp_buf_a_reg <= pwdata[15:0];
        TMR_CMP_B_OFS:  cmp_buf_b_reg <= pwdata[15:0];
        TMR_CAPT_OFS:   capture_value_reg <= pwdata[15:0];
        TMR_MASK_OFS:   mask_reg <= pwdata[2:0];
        TMR_DIR_OFS:    dir_reg <= pwdata[1:0];
        default:        ;
      endcase
    end
  end

  // ***************************************************************
  // Tick source: prescaler and external edges
  // ***************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pre_reg      <= '0;
      ext_prev_reg <= 1'b0;
    end
    else
    begin
      pre_reg      <= (tick_source_sel == TMR_SRC_STOP) ? '0 : pre_reg + 1'b1;
      ext_prev_reg <= ext_count_pin;
    end
  end

  always_comb
  begin
    case (tmr_src_t'(tick_source_sel))
      TMR_SRC_STOP:     timer_tick = 1'b0;
      TMR_SRC_DIV1:     timer_tick = 1'b1;
      TMR_SRC_DIV8:     timer_tick = (pre_reg[2:0] == 3'h7);
      TMR_SRC_DIV64:    timer_tick = (pre_reg[5:0] == 6'h3f);
      TMR_SRC_DIV256:   timer_tick = (pre_reg[7:0] == 8'hff);
      TMR_SRC_DIV1024:  timer_tick = (pre_reg == 10'h3ff);
      TMR_SRC_EXT_FALL: timer_tick = ext_prev_reg && !ext_count_pin;
      TMR_SRC_EXT_RISE: timer_tick = !ext_prev_reg && ext_count_pin;
      default:          timer_tick = 1'b0;
    endcase
  end

  // ***************************************************************
  // Counter
  // ***************************************************************
  always_comb
  begin
    case (mode.top_src)
      TMR_TOP_CMPA: top_val = compare_value_a_reg;
      TMR_TOP_CAPT: top_val = capture_value_reg;
      default:      top_val = mode.fixed_top;
    endcase
  end

  assign at_top    = (count_value_reg == top_val);
  assign at_bottom = (count_value_reg == TMR_BOTTOM);
  // Toggle is always legal in the non-PWM modes
  assign tog_ok    = fast ? waveform_mode_sel[3:1] == 3'b111
                   : dual ? waveform_mode_sel == 4'h9 || waveform_mode_sel == 4'hb
                   : 1'b1;

  // Tick logic runs on pclk with timer_tick as an enable
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count_value_reg <= TMR_BOTTOM;
      count_up_reg    <= 1'b1;
    end
    else if (count_wr)
      count_value_reg <= pwdata[15:0];
    else if (timer_tick)
    begin
      if (dual)
      begin
        if (count_up_reg && at_top)
        begin
          count_up_reg    <= 1'b0;
          count_value_reg <= count_value_reg - 1'b1;
        end
        else if (!count_up_reg && at_bottom)
        begin
          count_up_reg    <= 1'b1;
          count_value_reg <= count_value_reg + 1'b1;
        end
        else
          count_value_reg <= count_up_reg ? count_value_reg + 1'b1 : count_value_reg - 1'b1;
      end
      else
      begin
        count_up_reg <= 1'b1;
        if ((mode.fam != TMR_FAM_NORMAL) && at_top)
          count_value_reg <= TMR_BOTTOM;
        else
          count_value_reg <= count_value_reg + 1'b1;
      end
    end
  end

  // ***************************************************************
  // Compare buffer update point
  // ***************************************************************
  always_comb
  begin
    case (mode.fam)
      TMR_FAM_PFC:  upd_now = timer_tick && at_bottom;
      TMR_FAM_FAST: upd_now = timer_tick && at_top;
      TMR_FAM_PC:   upd_now = timer_tick && at_top && count_up_reg;
      default:      upd_now = 1'b1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      compare_value_a_reg <= TMR_BOTTOM;
      compare_value_b_reg <= TMR_BOTTOM;
    end
    else if (upd_now)
    begin
      compare_value_a_reg <= cmp_buf_a_reg;
      compare_value_b_reg <= cmp_buf_b_reg;
    end
  end

  // ***************************************************************
  // Matches, flags and interrupt
  // ***************************************************************
  always_comb
  begin
    case (mode.fam)
      TMR_FAM_FAST: ovf_evt = timer_tick && at_top;
      TMR_FAM_PC,
      TMR_FAM_PFC:  ovf_evt = timer_tick && at_bottom && !count_up_reg;
      default:      ovf_evt = timer_tick && count_value_reg == TMR_MAX;
    endcase
  end

  // Match seen this tick, flagged on the next tick
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      block_match_reg <= 1'b0;
      pend_a_reg      <= 1'b0;
      pend_b_reg      <= 1'b0;
    end
    else
    begin
      if (count_wr)
        block_match_reg <= 1'b1;
      else if (timer_tick)
        block_match_reg <= 1'b0;
      if (timer_tick)
      begin
        pend_a_reg <= !block_match_reg && count_value_reg == compare_value_a_reg;
        pend_b_reg <= !block_match_reg && count_value_reg == compare_value_b_reg;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      status_reg <= 3'h0;
    else
    begin
      if (wr_en && paddr == TMR_STATUS_OFS)
        status_reg <= status_reg & ~pwdata[2:0];
      if (ovf_evt)
        status_reg[TMR_ST_OVF] <= 1'b1;
      if (timer_tick && pend_a_reg)
        status_reg[TMR_ST_CMPA] <= 1'b1;
      if (timer_tick && pend_b_reg)
        status_reg[TMR_ST_CMPB] <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= |(status_reg & mask_reg);
  end

  // ***************************************************************
  // Waveform generators
  // ***************************************************************
  logic hit_a;
  logic hit_b;
  logic top_a;
  logic top_b;
  assign hit_a = timer_tick && !block_match_reg && count_value_reg == compare_value_a_reg;
  assign hit_b = timer_tick && !block_match_reg && count_value_reg == compare_value_b_reg;
  // Compare equal to TOP in fast PWM: act at TOP instead of on match
  assign top_a = fast && chan_a_output_mode[1] && compare_value_a_reg == top_val;
  assign top_b = fast && chan_b_output_mode[1] && compare_value_b_reg == top_val;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      level_a_reg <= 1'b0;
      level_b_reg <= 1'b0;
    end
    else
    begin
      if (fast && chan_a_output_mode[1] && timer_tick && at_top)
        level_a_reg <= top_a ? chan_a_output_mode[0] : ~chan_a_output_mode[0];
      else if (hit_a && !top_a)
        level_a_reg <= match_level(chan_a_output_mode, level_a_reg, count_up_reg, dual, tog_ok);
      else if (force_a && !dual && !fast)
        level_a_reg <= match_level(chan_a_output_mode, level_a_reg, 1'b1, 1'b0, 1'b1);
      if (fast && chan_b_output_mode[1] && timer_tick && at_top)
        level_b_reg <= top_b ? chan_b_output_mode[0] : ~chan_b_output_mode[0];
      else if (hit_b && !top_b && (chan_b_output_mode[1] || !(dual || fast)))
        level_b_reg <= match_level(chan_b_output_mode, level_b_reg, count_up_reg, dual, 1'b0 | !(dual || fast));
      else if (force_b && !dual && !fast)
        level_b_reg <= match_level(chan_b_output_mode, level_b_reg, 1'b1, 1'b0, 1'b1);
    end
  end

  // ***************************************************************
  // Pin override and drivers
  // ***************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      compare_out_a    <= 1'b0;
      compare_out_a_oe <= 1'b0;
      compare_out_b    <= 1'b0;
      compare_out_b_oe <= 1'b0;
    end
    else
    begin
      compare_out_a    <= level_a_reg;
      compare_out_b    <= level_b_reg;
      compare_out_a_oe <= (|chan_a_output_mode) && dir_reg[0];
      compare_out_b_oe <= (|chan_b_output_mode) && dir_reg[1];
    end
  end

endmodule

// *** pkg/tmr_pkg.sv ***
// Package for the 16-bit timer waveform-mode block: register map, fields, constants
// Overview of operation
// - All logic on pclk, tick is enable
// - Phase-frequency PWM updates compare at BOTTOM
// - Nonzero output mode overrides pin function
// - Pin driven only when direction is output
// - Non-PWM: disconnect, toggle, clear, set on match
// - Fast PWM: 10 non-inverting, 11 inverting
// - Fast PWM 01 toggles A in 14/15
// - Fast PWM compare equal TOP acts at TOP
// - Phase PWM: 10 clear up, set down
// - Phase PWM 01 toggles A in 9/11
// - Mode from ctrl A low, ctrl B high bits
// - Normal/clear-on-match modes: immediate update, MAX overflow
// - Modes 1-3 phase PWM fixed TOP
// - Fast PWM modes: TOP update, TOP overflow
// - Modes 8-11 TOP source and update point
// - Tick source select: stop, prescale, external edges
// - Counter write blocks next tick's match
package tmr_pkg;

  // ***************************************************************
  // Register map (byte addresses)
  // ***************************************************************
  localparam logic [11:0] TMR_CTRL_A_OFS  = 12'h080;
  localparam logic [11:0] TMR_CTRL_B_OFS  = 12'h084;
  localparam logic [11:0] TMR_FORCE_OFS   = 12'h088;
  localparam logic [11:0] TMR_COUNT_OFS   = 12'h08c;
  localparam logic [11:0] TMR_CMP_A_OFS   = 12'h090;
  localparam logic [11:0] TMR_CMP_B_OFS   = 12'h094;
  localparam logic [11:0] TMR_CAPT_OFS    = 12'h098;
  localparam logic [11:0] TMR_STATUS_OFS  = 12'h09c;
  localparam logic [11:0] TMR_MASK_OFS    = 12'h0a0;
  localparam logic [11:0] TMR_DIR_OFS     = 12'h0a4;

  localparam logic [7:0]  TMR_CTRL_A_RST  = 8'h00;
  localparam logic [7:0]  TMR_CTRL_A_WMSK = 8'hf3;
  localparam logic [4:0]  TMR_CTRL_B_RST  = 5'h00;
  localparam logic [15:0] TMR_MAX         = 16'hffff;
  localparam logic [15:0] TMR_TOP_8       = 16'h00ff;
  localparam logic [15:0] TMR_TOP_9       = 16'h01ff;
  localparam logic [15:0] TMR_TOP_10      = 16'h03ff;
  localparam logic [15:0] TMR_BOTTOM      = 16'h0000;

  // Status / mask bit positions
  localparam int TMR_ST_OVF   = 0;
  localparam int TMR_ST_CMPA  = 1;
  localparam int TMR_ST_CMPB  = 2;

  // Prescaler
  localparam int TMR_PRE_W = 10;

  typedef enum logic [2:0] {
    TMR_SRC_STOP  = 3'b000,
    TMR_SRC_DIV1  = 3'b001,
    TMR_SRC_DIV8  = 3'b010,
    TMR_SRC_DIV64 = 3'b011,
    TMR_SRC_DIV256 = 3'b100,
    TMR_SRC_DIV1024 = 3'b101,
    TMR_SRC_EXT_FALL = 3'b110,
    TMR_SRC_EXT_RISE = 3'b111
  } tmr_src_t;

  typedef enum logic [2:0] {
    TMR_FAM_NORMAL = 3'b000,
    TMR_FAM_CTC    = 3'b001,
    TMR_FAM_FAST   = 3'b010,
    TMR_FAM_PC     = 3'b011,
    TMR_FAM_PFC    = 3'b100,
    TMR_FAM_RSVD   = 3'b101
  } tmr_fam_t;

  typedef enum logic [1:0] {
    TMR_TOP_FIXED = 2'b00,
    TMR_TOP_CMPA  = 2'b01,
    TMR_TOP_CAPT  = 2'b10
  } tmr_topsrc_t;

  // Decoded waveform mode
  typedef struct packed {
    tmr_fam_t    fam;
    tmr_topsrc_t top_src;
    logic [15:0] fixed_top;
  } tmr_mode_t;

  // APB request
  typedef struct packed {
    logic        sel;
    logic        enable;
    logic        write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } tmr_apb_req_t;

  // Pin outputs
  typedef struct packed {
    logic val;
    logic oe;
  } tmr_pin_t;

endpackage

// *** bench/tmr_wave_sva.sv ***
// Checker of APB timing, pin enables, forced levels and interrupt masking
`timescale 1ns/1ps
module tmr_wave_sva
  import tmr_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        ext_count_pin,
  input wire logic        compare_out_a,
  input wire logic        compare_out_a_oe,
  input wire logic        compare_out_b,
  input wire logic        compare_out_b_oe,
  input wire logic        irq
);
  logic [7:0] ctrl_sh;
  logic [4:0] ctlb_sh;
  logic [1:0] dir_sh;
  logic [2:0] mask_sh;
  logic       wr_go;
  logic       mapped;
  logic       non_pwm;
  logic       frc_wr;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  assign wr_go   = psel && penable && pready && pwrite;
  assign mapped  = paddr >= TMR_CTRL_A_OFS && paddr <= TMR_DIR_OFS && paddr[1:0] == 2'b00;
  assign non_pwm = {ctlb_sh[4:3], ctrl_sh[1:0]} inside {4'd0, 4'd4, 4'd12};
  assign frc_wr  = wr_go && paddr == TMR_FORCE_OFS && non_pwm;

  // ********************************
  // Shadow of software writes
  // ********************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_sh <= TMR_CTRL_A_RST;
      ctlb_sh <= TMR_CTRL_B_RST;
      dir_sh  <= 2'h0;
      mask_sh <= 3'h0;
    end
    else if (wr_go)
    begin
      if (paddr == TMR_CTRL_A_OFS)
        ctrl_sh <= pwdata[7:0] & TMR_CTRL_A_WMSK;
      if (paddr == TMR_CTRL_B_OFS)
        ctlb_sh <= pwdata[4:0];
      if (paddr == TMR_DIR_OFS)
        dir_sh <= pwdata[1:0];
      if (paddr == TMR_MASK_OFS)
        mask_sh <= pwdata[2:0];
    end
  end

  // ********************************
  // Assertions
  // ********************************
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("ready outside an access cycle");
  a_ready_no_wait: assert property (psel && !penable |=> pready)
    else $error("ready missing in access cycle");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_refused_zero: assert property (pready && !mapped |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (pready && mapped |-> !pslverr)
    else $error("mapped access refused");
  a_ctrl_read_back: assert property (
    pready && !pwrite && paddr == TMR_CTRL_A_OFS |-> prdata == {24'h0, ctrl_sh})
    else $error("control A read mismatch");
  a_oe_a_follows: assert property (
    compare_out_a_oe == $past(dir_sh[0] && ctrl_sh[7:6] != 2'b00))
    else $error("pin A enable wrong");
  a_oe_b_follows: assert property (
    compare_out_b_oe == $past(dir_sh[1] && ctrl_sh[5:4] != 2'b00))
    else $error("pin B enable wrong");
  a_force_clear_a: assert property (
    frc_wr && pwdata[7] && ctrl_sh[7:6] == 2'b10 |-> ##[1:3] !compare_out_a)
    else $error("forced clear on A missing");
  a_force_set_b: assert property (
    frc_wr && pwdata[6] && ctrl_sh[5:4] == 2'b11 |-> ##[1:3] compare_out_b)
    else $error("forced set on B missing");
  a_irq_masked: assert property (mask_sh == 3'h0 && $past(mask_sh) == 3'h0 |-> !irq)
    else $error("interrupt while fully masked");
endmodule

bind tmr_wave tmr_wave_sva i_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .ext_count_pin(ext_count_pin),
  .compare_out_a(compare_out_a), .compare_out_a_oe(compare_out_a_oe),
  .compare_out_b(compare_out_b), .compare_out_b_oe(compare_out_b_oe), .irq(irq)
);

// *** bench/tb.sv ***
// Self-checking testbench of the timer: registers, forced levels, PWM duty, interrupt
`timescale 1ns/1ps
module tb;
  import tmr_pkg::*;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        ext_count_pin;
  logic        compare_out_a;
  logic        compare_out_a_oe;
  logic        compare_out_b;
  logic        compare_out_b_oe;
  logic        irq;
  int          err_total;
  int          checks_done;
  int          seed;
  int          k;
  int          top;
  int          ocr;
  int          hi;
  int          per;
  int          ex;
  logic        dual;
  logic [31:0] rd;
  logic        se;
  logic [31:0] v;
  logic [1:0]  om;
  logic [1:0]  oms [4] = '{2'b11, 2'b01, 2'b10, 2'b01};
  logic        lvl [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
  logic [3:0]  wms [15] = '{5, 6, 7, 5, 6, 7, 1, 2, 3, 1, 2, 3, 9, 11, 15};

  tmr_wave i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_count_pin(ext_count_pin),
    .compare_out_a(compare_out_a), .compare_out_a_oe(compare_out_a_oe),
    .compare_out_b(compare_out_b), .compare_out_b_oe(compare_out_b_oe), .irq(irq)
  );

  always #20 pclk = ~pclk;

  always @(posedge pclk)
    ext_count_pin <= $random(seed);

  // ********************************
  // Reporting and bus tasks
  // ********************************
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20)
    begin
      n++;
      @(posedge pclk);
    end
    chk("ready wait", 1'b1, n < 20);
    rd = prdata;
    se = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge pclk);
  endtask

  task automatic cfg(input logic [3:0] wm, input logic [1:0] o, input int c);
    apb(1'b1, TMR_CTRL_B_OFS, 32'h0);
    // Normal mode while stopped, so the compare value loads at once
    apb(1'b1, TMR_CTRL_A_OFS, 32'h0);
    apb(1'b1, TMR_COUNT_OFS, 32'h0);
    apb(1'b1, TMR_CMP_A_OFS, c);
    apb(1'b1, TMR_DIR_OFS, 32'h1);
    apb(1'b1, TMR_CTRL_A_OFS, {24'h0, o, 4'h0, wm[1:0]});
    apb(1'b1, TMR_CTRL_B_OFS, {27'h0, wm[3:2], 3'b001});
  endtask

  function automatic int top_of(input logic [3:0] wm);
    if (wm == 4'd1 || wm == 4'd5)
      return TMR_TOP_8;
    if (wm == 4'd2 || wm == 4'd6)
      return TMR_TOP_9;
    return TMR_TOP_10;
  endfunction

  // ********************************
  // Main sequence
  // ********************************
  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    ext_count_pin = 1'b0;
    seed = 32'ha65f;
    err_total = 0;
    checks_done = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, TMR_CTRL_A_OFS, 32'h0);
    chk("ctrl_a reset", 32'h0, rd);
    for (k = 0; k < 4; k++)
    begin
      v = $random(seed);
      apb(1'b1, TMR_CTRL_A_OFS, v);
      apb(1'b0, TMR_CTRL_A_OFS, 32'h0);
      chk("ctrl_a", {24'h0, v[7:0] & TMR_CTRL_A_WMSK}, rd);
    end
    apb(1'b0, 12'h0fc, 32'h0);
    chk("unmapped error", 1'b1, se);
    chk("unmapped data", 32'h0, rd);
    apb(1'b1, TMR_CTRL_B_OFS, 32'h0);
    apb(1'b1, TMR_DIR_OFS, 32'h3);
    for (k = 0; k < 4; k++)
    begin
      apb(1'b1, TMR_CTRL_A_OFS, {24'h0, oms[k], oms[k], 4'h0});
      apb(1'b1, TMR_FORCE_OFS, 32'hc0);
      idle(3);
      chk("out a forced", lvl[k], compare_out_a);
      chk("out b forced", lvl[k], compare_out_b);
      chk("oe a", 1'b1, compare_out_a_oe);
      chk("oe b", 1'b1, compare_out_b_oe);
    end
    apb(1'b1, TMR_DIR_OFS, 32'h0);
    idle(3);
    chk("oe a off", 1'b0, compare_out_a_oe);
    apb(1'b1, TMR_CTRL_A_OFS, 32'h0);
    apb(1'b1, TMR_CMP_A_OFS, 32'hfff0);
    apb(1'b1, TMR_COUNT_OFS, 32'hffe0);
    apb(1'b1, TMR_MASK_OFS, 32'h2);
    apb(1'b1, TMR_CTRL_B_OFS, 32'h1);
    idle(60);
    apb(1'b1, TMR_CTRL_B_OFS, 32'h0);
    apb(1'b0, TMR_STATUS_OFS, 32'h0);
    chk("match flag a", 1'b1, rd[1]);
    chk("overflow at max", 1'b1, rd[0]);
    idle(2);
    chk("irq on", 1'b1, irq);
    apb(1'b1, TMR_STATUS_OFS, 32'h2);
    apb(1'b0, TMR_STATUS_OFS, 32'h0);
    chk("flag cleared", 1'b0, rd[1]);
    idle(2);
    chk("irq off", 1'b0, irq);
    apb(1'b1, TMR_MASK_OFS, 32'h0);
    // About 78 cycles at divide-by-8 give nine ticks
    apb(1'b1, TMR_COUNT_OFS, 32'h0);
    apb(1'b1, TMR_CTRL_B_OFS, 32'h2);
    idle(76);
    apb(1'b1, TMR_CTRL_B_OFS, 32'h0);
    apb(1'b0, TMR_COUNT_OFS, 32'h0);
    chk("prescaled count", 32'h9, rd);
    for (k = 0; k < 15; k++)
    begin
      dual = wms[k] < 4'd4 || wms[k] == 4'd9 || wms[k] == 4'd11;
      if (k < 12)
      begin
        top = top_of(wms[k]);
        ocr = 1 + ($unsigned($random(seed)) % (top - 1));
        om = (k % 6 < 3) ? 2'b10 : 2'b11;
      end
      else
      begin
        top = 64 + ($unsigned($random(seed)) % 192);
        ocr = top;
        om = 2'b01;
      end
      per = dual ? 2 * top : top + 1;
      cfg(wms[k], om, ocr);
      idle(per);
      hi = 0;
      repeat (2 * per)
      begin
        @(negedge pclk);
        hi += compare_out_a;
      end
      ex = dual ? 4 * ocr : 2 * (ocr + 1);
      if (k >= 12)
        ex = per;
      else if (om == 2'b11)
        ex = 2 * per - ex;
      if (dual && k < 12 && hi > ex - 4 && hi < ex + 4)
        hi = ex;
      chk("duty", ex, hi);
    end
    conclude();
  end

  initial
  begin
    #(90000 * 40);
    err_total++;
    conclude();
  end
endmodule
